// ===== acc_core_model.sv
// analog core model: latches a code at the sample command.
// assumes one-cycle sample and done pulses from acc_top on aclk.
`timescale 1ns/100ps
module acc_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       core_sample,
  input  wire logic       core_done,
  input  wire logic [9:0] sample_code,
  output logic      [9:0] core_code
);
  logic hold; // code is promised stable only until done
  // outside a conversion the code toggles, so a late capture shows
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hold <= 1'b0;
    else if (core_sample)
      hold <= 1'b1;
    else if (core_done)
      hold <= 1'b0;
    if (core_sample)
      core_code <= sample_code;
    else if (!hold)
      core_code <= ~core_code;
  end
endmodule

// ===== acc_pkg.sv
// package for the conversion control block: register offsets, field positions,
// reset values and timing counts.
// assumes a 32-bit AXI4-Lite register bus and a 250 MHz system clock.
package acc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SEL    = 8'h00; // selection_register
  localparam logic [7:0] OFF_CTRL_A = 8'h04; // converter_control_a
  localparam logic [7:0] OFF_CTRL_B = 8'h08; // converter_control_b
  localparam logic [7:0] OFF_RES_L  = 8'h0C; // result_low_byte
  localparam logic [7:0] OFF_RES_H  = 8'h10; // result_high_byte
  localparam logic [7:0] OFF_POWER  = 8'h14; // power reduction
  // control a field positions
  localparam int CA_ENABLE = 7;
  localparam int CA_START  = 6;
  localparam int CA_AUTO   = 5;
  localparam int CA_DONE   = 4;
  // selection register field positions
  localparam int SEL_LEFT  = 5;
  localparam int SEL_REF   = 6;
  // reset values
  localparam logic [7:0] SEL_RESET  = 8'h00;
  localparam logic [7:0] CA_RESET   = 8'h00;
  localparam logic [2:0] TS_RESET   = 3'h0;
  localparam logic       PWR_RESET  = 1'b1;
  // trigger source code that selects the done flag (free running)
  localparam logic [2:0] TS_FREE    = 3'h0;
  // conversion lengths in converter clocks
  localparam logic [4:0] CONV_NORMAL = 5'd13;
  localparam logic [4:0] CONV_FIRST  = 5'd25;
  // converter clock prescale: divide 2^(n+1) with n from control a bits 2:0
  localparam int PRESC_W = 8;
  // sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_WAIT = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_t;
endpackage

// ===== acc_sync.sv
// two flip-flop synchroniser with rising edge detect on the second stage.
// assumes the input comes from outside the aclk domain.
`timescale 1ns/100ps
module acc_sync
  import acc_pkg::*;
(
  input  wire logic aclk,    // system clock
  input  wire logic aresetn, // sync reset, active low
  input  wire logic d,       // asynchronous level
  output logic      q,       // synchronised level
  output logic      rise     // one-cycle pulse on rising edge of q
);
  logic meta; // first stage, read only by q
  logic q_d;  // delayed copy for edge detect

  // edge is taken between second and third stage, never from meta
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
      q_d  <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
      q_d  <= q;
    end
  end

  assign rise = q & ~q_d;
endmodule

// ===== acc_top.sv
// conversion control for a 10-bit successive approximation converter.
// assumes an AXI4-Lite master on aclk and an analog core that holds its code stable
// while core_done is high; trigger inputs are asynchronous levels.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module acc_top
  import acc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // trigger sources 1..7 (index 0 unused, done flag is source 0)
  input  wire logic [7:1]  trig_in,
  // analog side
  output logic [3:0]       channel_select,  // applied channel to the multiplexer
  output logic [1:0]       reference_select, // applied reference switch setting
  output logic             core_enable,     // analog power
  output logic             core_sample,     // sample command, high one aclk cycle
  output logic             core_done,       // conversion done indication
  input  wire logic [9:0]  core_code        // finished code, stable at core_done
);
  import acc_pkg::*;

  // software visible state
  logic [7:0]  sel_reg;       // selection_register temporary copy
  logic        enable;        // converter_enable
  logic        start;         // conversion_start_bit
  logic        auto_en;       // auto_trigger_enable
  logic        done_flag;     // conversion_done_flag
  logic        int_en;        // interrupt enable bit, stored only
  logic [2:0]  presc_sel;     // prescaler select
  logic [2:0]  trig_sel;      // trigger_source_select
  logic        power_red;     // converter_power_reduction
  logic [9:0]  result;        // last accepted result
  logic        locked;        // low byte read, updates blocked
  // sequencer
  acc_state_t  state;
  logic [4:0]  conv_cnt;      // converter clocks elapsed
  logic        first_conv;    // next conversion is the long one
  logic [PRESC_W-1:0] presc;  // prescaler counter
  logic        trig_prev;     // previous selected trigger level

  // synchronise external triggers, one per source
  logic [7:1]  trig_s;
  genvar gi;
  generate
    for (gi = 1; gi < 8; gi++)
    begin : g_sync
      acc_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (trig_in[gi]),
        .q       (trig_s[gi]),
        .rise    ()
      );
    end
  endgenerate

  // bus decode
  wire wr_fire   = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_fire   = s_axi_arvalid & ~s_axi_rvalid;
  wire wsel_sel  = wr_fire & (s_axi_awaddr == OFF_SEL) & s_axi_wstrb[0];
  wire wsel_ca   = wr_fire & (s_axi_awaddr == OFF_CTRL_A) & s_axi_wstrb[0];
  wire wsel_cb   = wr_fire & (s_axi_awaddr == OFF_CTRL_B) & s_axi_wstrb[0];
  wire wsel_pwr  = wr_fire & (s_axi_awaddr == OFF_POWER) & s_axi_wstrb[0];
  wire w_known   = (s_axi_awaddr == OFF_SEL) | (s_axi_awaddr == OFF_CTRL_A) |
                   (s_axi_awaddr == OFF_CTRL_B) | (s_axi_awaddr == OFF_POWER) |
                   (s_axi_awaddr == OFF_RES_L) | (s_axi_awaddr == OFF_RES_H);
  wire rd_low    = rd_fire & (s_axi_araddr == OFF_RES_L);
  wire rd_high   = rd_fire & (s_axi_araddr == OFF_RES_H);

  // power reduction gates the whole converter
  wire run       = enable & ~power_red;
  wire sw_start  = wsel_ca & s_axi_wdata[CA_START] & run;
  wire done_clr  = wsel_ca & s_axi_wdata[CA_DONE];

  // prescaler tick: divide by 2^(presc_sel+1), minimum 2
  wire [PRESC_W-1:0] presc_mask = PRESC_W'((9'h002 << presc_sel) - 9'h001);
  wire tick      = ((presc & presc_mask) == presc_mask);

  // selected trigger level; source 0 is the done flag
  wire trig_lvl  = (trig_sel == TS_FREE) ? done_flag : trig_s[trig_sel];
  wire trig_edge = auto_en & run & trig_lvl & ~trig_prev;
  wire busy      = (state != ACC_IDLE);
  wire hw_start  = trig_edge & ~busy;
  wire conv_len_hit = (conv_cnt == (first_conv ? CONV_FIRST : CONV_NORMAL));
  wire complete  = run & (state == ACC_CONV) & tick & conv_len_hit; // abort beats a late tick
  // free running: done flag source restarts at once, flag state irrelevant
  wire free_run  = auto_en & (trig_sel == TS_FREE);

  // result byte layouts
  wire [7:0] res_lo  = sel_reg[SEL_LEFT] ? {result[1:0], 6'h00} : result[7:0];
  wire [7:0] res_hi  = sel_reg[SEL_LEFT] ? result[9:2] : {6'h00, result[9:8]};
  wire [7:0] ctrl_a  = {enable, start | busy, auto_en, done_flag, int_en, presc_sel};

  // read data mux, unmapped reads return zero with OKAY
  logic [7:0] rd_byte;
  always_comb
  begin
    case (s_axi_araddr)
      OFF_SEL:    rd_byte = sel_reg;
      OFF_CTRL_A: rd_byte = ctrl_a;
      OFF_CTRL_B: rd_byte = {5'h00, trig_sel};
      OFF_RES_L:  rd_byte = res_lo;
      OFF_RES_H:  rd_byte = res_hi;
      OFF_POWER:  rd_byte = {7'h00, power_red};
      default:    rd_byte = 8'h00;
    endcase
  end

  // AXI handshake: one-cycle ready pulses, response held until accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      s_axi_arready <= rd_fire;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_known ? 2'h0 : 2'h2; // slverr on unmapped write
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_reg   <= SEL_RESET;
      enable    <= CA_RESET[CA_ENABLE];
      auto_en   <= CA_RESET[CA_AUTO];
      int_en    <= 1'b0;
      presc_sel <= 3'h0;
      trig_sel  <= TS_RESET;
      power_red <= PWR_RESET;
    end
    else
    begin
      if (wsel_sel)
        sel_reg <= s_axi_wdata[7:0];
      if (wsel_ca)
      begin
        enable    <= s_axi_wdata[CA_ENABLE];
        auto_en   <= s_axi_wdata[CA_AUTO];
        int_en    <= s_axi_wdata[3];
        presc_sel <= s_axi_wdata[2:0];
      end
      if (wsel_cb)
        trig_sel <= s_axi_wdata[2:0];
      if (wsel_pwr)
        power_red <= s_axi_wdata[0];
    end
  end

  // done flag: set on completion wins over a write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_flag <= 1'b0;
    else if (complete)
      done_flag <= 1'b1;
    else if (done_clr)
      done_flag <= 1'b0;
  end

  // prescaler held in reset while disabled, cleared when a trigger edge starts a conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      presc <= '0;
    else if (hw_start)
      presc <= '0;
    else
      presc <= presc + PRESC_W'(1);
  end

  // sequencer: software start waits for the next converter clock, trigger starts at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      state      <= ACC_IDLE;
      start      <= 1'b0;
      conv_cnt   <= 5'd0;
      first_conv <= 1'b1;
      trig_prev  <= trig_lvl; // a level already high at enable is no edge
    end
    else
    begin
      trig_prev <= trig_lvl;
      case (state)
        ACC_IDLE:
        begin
          if (hw_start)
          begin
            state    <= ACC_CONV;
            start    <= 1'b1;
            conv_cnt <= 5'd1;
          end
          else if (sw_start)
          begin
            state <= ACC_WAIT;
            start <= 1'b1;
          end
        end
        ACC_WAIT:
          if (tick)
          begin
            state    <= ACC_CONV;
            conv_cnt <= 5'd1;
          end
        ACC_CONV:
          if (tick)
          begin
            if (complete)
            begin
              first_conv <= 1'b0;
              conv_cnt   <= 5'd1;
              if (!free_run)
              begin
                state <= ACC_IDLE;
                start <= 1'b0;
              end
            end
            else
              conv_cnt <= conv_cnt + 5'd1;
          end
        default:
          state <= ACC_IDLE;
      endcase
    end
  end

  // result capture and read lock; a low read in the completion cycle keeps the old pair
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result <= 10'h000;
      locked <= 1'b0;
    end
    else
    begin
      if (complete && !locked && !rd_low)
        result <= core_code;
      if (rd_high)
        locked <= 1'b0;
      else if (rd_low)
        locked <= 1'b1;
    end
  end

  // analog side: while the converter runs, selections follow software until a conversion locks them
  wire sel_open = ~busy | complete;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_select   <= 4'h0;
      reference_select <= 2'h0;
      core_enable      <= 1'b0;
      core_sample      <= 1'b0;
      core_done        <= 1'b0;
    end
    else
    begin
      core_enable <= run;
      core_done   <= complete;
      core_sample <= run & (state == ACC_CONV) & tick & (conv_cnt == (first_conv ? 5'd13 : 5'd1));
      if (run && sel_open)
      begin
        channel_select   <= sel_reg[3:0];
        reference_select <= sel_reg[7:6];
      end
    end
  end
endmodule

// ===== acc_top_asserts.sv
// checker for acc_top: bus answers and analog core sequencing.
// assumes it is bound to acc_top and sees only its ports.
`timescale 1ns/100ps
module acc_top_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  channel_select,
  input wire logic [1:0]  reference_select,
  input wire logic        core_enable,
  input wire logic        core_sample,
  input wire logic        core_done
);
  logic        busy; // a conversion has sampled and not finished
  logic [12:0] gap;  // cycles since the last sample command
  // disable aborts, so busy drops with the enable as well
  always_ff @(posedge aclk)
  begin
    if (!aresetn || core_done || !core_enable)
      busy <= 1'b0;
    else if (core_sample)
      busy <= 1'b1;
  end
  // gap bounds how long a conversion may run
  always_ff @(posedge aclk)
  begin
    if (!aresetn || core_sample)
      gap <= 13'h0;
    else if (busy)
      gap <= gap + 13'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the tail of a conversion is at least 12 ticks of 2 cycles
  sequence s_quiet;
    !core_done [*8];
  endsequence
  // selections stay locked after the sample point
  sequence s_held;
    ($stable(channel_select) && $stable(reference_select)) [*8];
  endsequence
  sample_pulse_a: assert property (core_sample |=> !core_sample)
    else $error("sample command longer than one cycle");
  done_pulse_a: assert property (core_done |=> !core_done)
    else $error("done indication longer than one cycle");
  sample_on_a: assert property (core_sample |-> core_enable)
    else $error("sample while converter disabled");
  conv_len_a: assert property (core_sample |=> s_quiet)
    else $error("conversion ended too soon");
  sel_hold_a: assert property (core_sample |=> s_held)
    else $error("selection changed during conversion");
  one_sample_a: assert property (busy |-> !core_sample)
    else $error("second sample inside one conversion");
  conv_end_a: assert property (busy |-> gap < 13'd7000)
    else $error("conversion never finished");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  rd_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer withdrawn");
  rd_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule

// ===== test_acc_top.sv
// self-checking bench for acc_top: registers, conversions, triggers.
// assumes acc_core_model on the analog side and the checker bound below.
`timescale 1ns/100ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_acc_top;
  import acc_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF; // full byte writes only
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [7:1]  trig_in = 7'h00;
  logic [3:0]  channel_select;
  logic [1:0]  reference_select;
  logic        core_enable;
  logic        core_sample;
  logic        core_done;
  logic [9:0]  core_code;
  logic [9:0]  sample_code = 10'h000; // code the core model will hand back
  logic [31:0] rv;                    // last read data
  logic [1:0]  bq;                    // last write response
  logic [1:0]  rq;                    // last read response
  int          failures = 0;
  int          samples_checked = 0;
  int          smp = 0;               // sample commands seen
  int          n;
  acc_top acc_top_i (.*);
  acc_core_model acc_core_model_i (.*);
  always #2 aclk = ~aclk;
  // count conversions by their sample command
  always @(posedge aclk)
    if (core_sample)
      smp++;
  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo();
    failures++;
    stop_test();
  endtask
  // write: both channels offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int k = 0; k <= 50; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
      if (k == 50)
        tmo();
    end
    bq = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // read: rready may be raised lag cycles late, then held until rvalid
  task automatic rd(input logic [7:0] a, input int lag = 0);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= (lag == 0);
    for (int k = 0; k <= 50; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (k + 1 == lag)
        s_axi_rready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready)
        break;
      if (k == 50)
        tmo();
    end
    rv = s_axi_rdata;
    rq = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // wait for the done pulse, n gives the cycles waited
  task automatic wdone(output int w);
    for (int k = 0; k <= 8000; k++)
    begin
      @(posedge aclk);
      w = k;
      if (core_done)
        break;
      if (k == 8000)
        tmo();
    end
  endtask
  task automatic t_regs();
    rd(OFF_POWER);
    `CK(rv, 32'h1)
    rd(OFF_CTRL_B);
    `CK(rv, 32'h0)
    rd(8'h3C);
    `CK(rv, 32'h0)
    `CK(rq, 2'h0)
    wr(8'h3C, 32'hFF);
    `CK(bq, 2'h2)
    wr(OFF_CTRL_A, 32'h80);
    `CK(bq, 2'h0)
    `CK(core_enable, 1'b0)
    wr(OFF_POWER, 32'h0);
    `CK(core_enable, 1'b1)
    $display("t_regs done");
  endtask
  task automatic t_single();
    wr(OFF_SEL, 32'h45);
    sample_code <= 10'h2A5;
    wr(OFF_CTRL_A, 32'hC0);
    rd(OFF_CTRL_A);
    `CK(rv[CA_START], 1'b1)
    wr(OFF_SEL, 32'h43);
    `CK(channel_select, 4'h5)
    wdone(n);
    `CK(n inside {[36:50]}, 1'b1)
    repeat (2) @(posedge aclk);
    `CK(channel_select, 4'h3)
    `CK(reference_select, 2'h1)
    rd(OFF_CTRL_A);
    `CK(rv[7:4], 4'h9)
    rd(OFF_RES_L);
    `CK(rv, 32'hA5)
    rd(OFF_RES_H);
    `CK(rv, 32'h02)
    $display("t_single done");
  endtask
  task automatic t_left();
    wr(OFF_CTRL_A, 32'h90);
    wr(OFF_SEL, 32'h23);
    rd(OFF_SEL, 2);
    `CK(rv, 32'h23)
    sample_code <= 10'h1CB;
    wr(OFF_CTRL_A, 32'hC0);
    wdone(n);
    `CK(n inside {[20:30]}, 1'b1)
    rd(OFF_RES_L);
    `CK(rv, 32'hC0)
    rd(OFF_RES_H);
    `CK(rv, 32'h72)
    $display("t_left done");
  endtask
  // low byte read locks the pair until the high byte is read
  task automatic t_lock();
    wr(OFF_CTRL_A, 32'h90);
    rd(OFF_RES_L);
    sample_code <= 10'h055;
    wr(OFF_CTRL_A, 32'hC0);
    wdone(n);
    rd(OFF_CTRL_A);
    `CK(rv[CA_DONE], 1'b1)
    rd(OFF_RES_H);
    `CK(rv, 32'h72)
    wr(OFF_CTRL_A, 32'hD1);
    wdone(n);
    `CK(n inside {[48:58]}, 1'b1)
    rd(OFF_RES_H);
    `CK(rv, 32'h15)
    $display("t_lock done");
  endtask
  task automatic t_trig();
    wr(OFF_CTRL_B, 32'h1);
    wr(OFF_CTRL_A, 32'hB0);
    smp = 0;
    trig_in <= 7'h02;
    repeat (20) @(posedge aclk);
    `CK(smp, 0)
    trig_in <= 7'h03;
    repeat (10) @(posedge aclk);
    trig_in <= 7'h02;
    repeat (6) @(posedge aclk);
    trig_in <= 7'h03;
    wdone(n);
    repeat (60) @(posedge aclk);
    `CK(smp, 1)
    wr(OFF_CTRL_A, 32'hF0);
    wdone(n);
    `CK(smp, 2)
    trig_in <= 7'h00;
    $display("t_trig done");
  endtask
  // flag left set on entry: free running must not care
  task automatic t_free();
    wr(OFF_CTRL_B, 32'h0);
    smp = 0;
    wr(OFF_CTRL_A, 32'hE0);
    wdone(n);
    wdone(n);
    wdone(n);
    rd(OFF_CTRL_A);
    `CK(rv[CA_START], 1'b1)
    `CK(smp >= 3, 1'b1)
    wr(OFF_CTRL_A, 32'h00);
    wr(OFF_SEL, 32'h87);
    `CK(channel_select, 4'h3)
    `CK(reference_select, 2'h0)
    $display("t_free done");
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_single();
    t_left();
    t_lock();
    t_trig();
    t_free();
    stop_test();
  end
endmodule
bind acc_top acc_top_asserts acc_top_asserts_i (.*);
